// file: rtl/nfc_init_pkg.sv
package nfc_init_pkg;
	// =========================================================
	// register map (byte addresses)
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CMD = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_TXCNT = 8'h0C;
	localparam logic [7:0] A_GPT = 8'h10;
	localparam logic [7:0] A_NRT = 8'h14;
	localparam logic [7:0] A_MRT = 8'h18;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// =========================================================
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [7:0] TXCNT_RST = 8'h00;
	localparam logic [15:0] GPT_RST = 16'h0010;
	localparam logic [15:0] NRT_RST = 16'h0400;
	localparam logic [15:0] MRT_RST = 16'h0010;
	// =========================================================
	// framing constants
	localparam logic [7:0] START_BYTE = 8'hF0;
	localparam logic [15:0] CRC_PRESET = 16'h6363;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [15:0] CRC_RESIDUE = 16'h0000;
	// bit rate codes: carrier / 128, / 64, / 32
	localparam logic [1:0] RATE_FC128 = 2'h0;
	localparam logic [1:0] RATE_FC64 = 2'h1;
	localparam logic [1:0] RATE_FC32 = 2'h2;
	// =========================================================
	// timing counts in clock cycles
	localparam int unsigned CA_CYC_DEF = 1000;
	localparam int unsigned INIT_GUARD_DEF = 1000;
	localparam int unsigned RESP_GUARD_DEF = 1000;
	// =========================================================
	// types
	typedef struct packed {
		logic [20:0] rsv;
		logic pm_en;
		logic am_en;
		logic response_ca_count_hi;
		logic response_ca_count_lo;
		logic [1:0] rate;
		logic transport_frame_enable;
		logic ext_field_detect_enable;
		logic auto_response_ca_enable;
		logic targ;
		logic act;
	} ctrl_t;
	typedef struct packed {
		logic soft_err;
		logic crc_err;
		logic rx_end;
		logic nre;
		logic eof;
		logic eon;
		logic cac;
		logic cat;
	} evt_t;
	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_INIT_ON = 3'h1,
		CMD_RESP_ON = 3'h2,
		CMD_TX = 3'h3,
		CMD_PRESET = 3'h4
	} cmd_t;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_CA = 4'h1,
		S_GUARD = 4'h2,
		S_TX = 4'h3,
		S_HOLD = 4'h4,
		S_WAIT = 4'h5,
		S_MASK = 4'h6,
		S_RX = 4'h7
	} seq_t;
	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} axil_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_t;
	typedef struct packed {
		logic start;
		logic valid;
		logic last;
		logic [7:0] data;
	} rx_in_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} byte_out_t;

	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_byte
endpackage : nfc_init_pkg

// file: rtl/nfc_active_initiator_seq.sv
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - length byte is transmit count plus one
// - after transmit, parse receiver for reply
// - check start byte, store length and data
// - check received CRC bytes internally
// - wrong start byte: store data, flag error
// - field on while sending, off while receiving
// - one bit rate, carrier/128/64/32, both ways
// - preset enables amplitude channel, disables phase
// - preset sets transport frame enable in active mode
// - field-on commands do avoidance, transmit sends
// - auto response starts avoidance on field off
// - active mode sets field detector enable
// - peer threshold sensing, avoidance threshold commands
// - field-on commands and auto response drive transmitter enable
// - field off after general timer post transmit
// - no collision: field on, done after guard
// - no-response timer runs until target field
// - target field: flag, mask timer, then receive
// - field drop: flag, auto response field-on
// - send start, length, data, two CRC bytes
// - collision: flag, field stays off, back to idle
module nfc_active_initiator_seq #(
	parameter int unsigned CA_CYC = nfc_init_pkg::CA_CYC_DEF,
	parameter int unsigned INIT_GUARD_CYC = nfc_init_pkg::INIT_GUARD_DEF,
	parameter int unsigned RESP_GUARD_CYC = nfc_init_pkg::RESP_GUARD_DEF
) (
	// clock and reset
	input wire logic CLK_I,
	input wire logic SRST_I,
	// register bus
	input wire nfc_init_pkg::axil_req_t AXI_REQ_I,
	output nfc_init_pkg::axil_rsp_t AXI_RSP_O,
	// external field detector
	input wire logic FIELD_PEER_I,
	input wire logic FIELD_CA_I,
	output logic FD_EN_O,
	output logic THR_CA_O,
	// rf front end
	output logic TX_EN_O,
	output logic AM_EN_O,
	output logic PM_EN_O,
	output logic [1:0] RATE_O,
	// framed byte streams
	output nfc_init_pkg::byte_out_t TX_O,
	input wire logic TX_READY_I,
	input wire nfc_init_pkg::rx_in_t RX_I,
	// fifo
	input wire logic [7:0] FIFO_RDATA_I,
	output logic FIFO_RE_O,
	output nfc_init_pkg::byte_out_t FIFO_W_O
);
	// =========================================================
	// state
	typedef struct packed {
		logic fp1;
		logic fp2;
		logic fc1;
		logic fc2;
		logic awready;
		logic wready;
		logic bvalid;
		logic arready;
		logic rvalid;
		logic aw_got;
		logic w_got;
		logic [1:0] bresp;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [7:0] awaddr;
		nfc_init_pkg::ctrl_t ctrl;
		nfc_init_pkg::evt_t evt;
		logic [7:0] txcnt;
		logic [15:0] gpt;
		logic [15:0] nrt;
		logic [15:0] mrt;
		nfc_init_pkg::seq_t state;
		logic tx_en;
		logic thr_ca;
		logic resp;
		logic [31:0] cnt;
		logic [8:0] pos;
		logic [15:0] crc;
		nfc_init_pkg::byte_out_t tx;
		logic fifo_re;
		logic [8:0] rx_n;
		logic [7:0] h0;
		logic [7:0] h1;
		nfc_init_pkg::byte_out_t fw;
	} st_t;

	st_t s_r;
	st_t s_nxt;

	// =========================================================
	// next state
	always_comb begin
		st_t n;
		nfc_init_pkg::evt_t ev;
		nfc_init_pkg::evt_t clr;
		nfc_init_pkg::cmd_t cmd;
		logic [31:0] wm;
		logic [31:0] rd;
		logic rd_ok;
		logic wr_ok;
		logic [8:0] nb;
		n = s_r;
		ev = '0;
		clr = '0;
		cmd = nfc_init_pkg::CMD_NONE;
		wm = '0;
		rd = '0;
		rd_ok = 1'b1;
		wr_ok = 1'b1;
		nb = {1'b0, s_r.txcnt};
		// two-flop synchronisers for the detector comparators
		n.fp1 = FIELD_PEER_I;
		n.fp2 = s_r.fp1;
		n.fc1 = FIELD_CA_I;
		n.fc2 = s_r.fc1;
		n.fw.valid = 1'b0;
		n.fifo_re = 1'b0;

		// write channels, taken in either order
		if (AXI_REQ_I.awvalid && s_r.awready) begin
			n.awready = 1'b0;
			n.aw_got = 1'b1;
			n.awaddr = AXI_REQ_I.awaddr[7:0];
		end
		if (AXI_REQ_I.wvalid && s_r.wready) begin
			n.wready = 1'b0;
			n.w_got = 1'b1;
			n.wdata = AXI_REQ_I.wdata;
			n.wstrb = AXI_REQ_I.wstrb;
		end
		for (int i = 0; i < 4; i++) begin
			wm[8*i +: 8] = {8{s_r.wstrb[i]}};
		end
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
			n.bvalid = 1'b1;
			case (s_r.awaddr)
				nfc_init_pkg::A_CTRL: begin
					n.ctrl = nfc_init_pkg::ctrl_t'((s_r.ctrl & ~wm)
						| (s_r.wdata & wm));
					n.ctrl.rsv = '0;
					if (n.ctrl.act && !s_r.ctrl.act) begin
						n.ctrl.ext_field_detect_enable = 1'b1;
					end
				end
				nfc_init_pkg::A_CMD: begin
					if (s_r.wstrb[0]) begin
						cmd = nfc_init_pkg::cmd_t'(s_r.wdata[2:0]);
					end
				end
				nfc_init_pkg::A_STAT: begin
					clr = nfc_init_pkg::evt_t'(s_r.wdata[7:0] & wm[7:0]);
				end
				nfc_init_pkg::A_TXCNT: begin
					if (s_r.wstrb[0]) begin
						n.txcnt = s_r.wdata[7:0];
					end
				end
				nfc_init_pkg::A_GPT: begin
					n.gpt = (s_r.gpt & ~wm[15:0]) | (s_r.wdata[15:0] & wm[15:0]);
				end
				nfc_init_pkg::A_NRT: begin
					n.nrt = (s_r.nrt & ~wm[15:0]) | (s_r.wdata[15:0] & wm[15:0]);
				end
				nfc_init_pkg::A_MRT: begin
					n.mrt = (s_r.mrt & ~wm[15:0]) | (s_r.wdata[15:0] & wm[15:0]);
				end
				default: begin
					wr_ok = 1'b0;
				end
			endcase
			n.bresp = wr_ok ? nfc_init_pkg::RESP_OK : nfc_init_pkg::RESP_SLVERR;
		end
		if (s_r.bvalid && AXI_REQ_I.bready) begin
			n.bvalid = 1'b0;
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.awready = 1'b1;
			n.wready = 1'b1;
		end

		// read channel
		case (AXI_REQ_I.araddr[7:0])
			nfc_init_pkg::A_CTRL: rd = s_r.ctrl;
			nfc_init_pkg::A_CMD: rd = '0;
			nfc_init_pkg::A_STAT: rd = {19'h00000, s_r.tx_en, s_r.state, s_r.evt};
			nfc_init_pkg::A_TXCNT: rd = {24'h000000, s_r.txcnt};
			nfc_init_pkg::A_GPT: rd = {16'h0000, s_r.gpt};
			nfc_init_pkg::A_NRT: rd = {16'h0000, s_r.nrt};
			nfc_init_pkg::A_MRT: rd = {16'h0000, s_r.mrt};
			default: rd_ok = 1'b0;
		endcase
		if (AXI_REQ_I.arvalid && s_r.arready) begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rdata = rd;
			n.rresp = rd_ok ? nfc_init_pkg::RESP_OK : nfc_init_pkg::RESP_SLVERR;
		end
		if (s_r.rvalid && AXI_REQ_I.rready) begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end

		// =========================================================
		// direct commands
		if (cmd == nfc_init_pkg::CMD_PRESET) begin
			n.ctrl.am_en = 1'b1;
			n.ctrl.pm_en = 1'b0;
			if (n.ctrl.act) begin
				n.ctrl.transport_frame_enable = 1'b1;
			end
		end
		// commands other than preset act only in active initiator mode, sequencer idle
		if (s_r.ctrl.act && !s_r.ctrl.targ
			&& s_r.state == nfc_init_pkg::S_IDLE) begin
			case (cmd)
				nfc_init_pkg::CMD_INIT_ON, nfc_init_pkg::CMD_RESP_ON: begin
					if (!s_r.tx_en) begin
						n.state = nfc_init_pkg::S_CA;
						n.resp = (cmd == nfc_init_pkg::CMD_RESP_ON);
						n.thr_ca = 1'b1;
						n.cnt = CA_CYC;
					end
				end
				nfc_init_pkg::CMD_TX: begin
					if (s_r.tx_en) begin
						n.state = nfc_init_pkg::S_TX;
						n.pos = '0;
						n.crc = nfc_init_pkg::CRC_PRESET;
					end
				end
				default: begin
				end
			endcase
		end

		// =========================================================
		// sequencer
		case (s_r.state)
			nfc_init_pkg::S_CA: begin
				if (s_r.fc2) begin
					ev.cac = 1'b1;
					n.thr_ca = 1'b0;
					n.state = nfc_init_pkg::S_IDLE;
				end else if (s_r.cnt == 32'h0) begin
					// single avoidance window: repeat count is zero
					n.tx_en = 1'b1;
					n.thr_ca = 1'b0;
					n.state = nfc_init_pkg::S_GUARD;
					n.cnt = s_r.resp ? RESP_GUARD_CYC : INIT_GUARD_CYC;
				end else begin
					n.cnt = s_r.cnt - 32'h1;
				end
			end
			nfc_init_pkg::S_GUARD: begin
				if (s_r.cnt == 32'h0) begin
					ev.cat = 1'b1;
					n.state = nfc_init_pkg::S_IDLE;
				end else begin
					n.cnt = s_r.cnt - 32'h1;
				end
			end
			nfc_init_pkg::S_TX: begin
				// a byte taken while the fifo head refreshes is not resent
				if (s_r.tx.valid && TX_READY_I) begin
					n.tx.valid = 1'b0;
				end
				// a popped fifo head needs one cycle to refresh
				if ((!s_r.tx.valid || TX_READY_I) && !s_r.fifo_re) begin
					if (s_r.pos <= nb + 9'h003) begin
						n.tx.valid = 1'b1;
						n.pos = s_r.pos + 9'h001;
						if (s_r.pos == 9'h000) begin
							n.tx.data = nfc_init_pkg::START_BYTE;
						end else if (s_r.pos == 9'h001) begin
							n.tx.data = s_r.txcnt + 8'h01;
						end else if (s_r.pos < nb + 9'h002) begin
							n.tx.data = FIFO_RDATA_I;
							n.fifo_re = 1'b1;
						end else if (s_r.pos == nb + 9'h002) begin
							n.tx.data = s_r.crc[7:0];
						end else begin
							n.tx.data = s_r.crc[15:8];
						end
						if (s_r.pos < nb + 9'h002) begin
							n.crc = nfc_init_pkg::crc_byte(s_r.crc, n.tx.data);
						end
					end else begin
						n.tx.valid = 1'b0;
						n.state = nfc_init_pkg::S_HOLD;
						n.cnt = {16'h0000, s_r.gpt};
					end
				end
			end
			nfc_init_pkg::S_HOLD: begin
				if (s_r.cnt == 32'h0) begin
					n.tx_en = 1'b0;
					n.state = nfc_init_pkg::S_WAIT;
					n.cnt = {16'h0000, s_r.nrt};
				end else begin
					n.cnt = s_r.cnt - 32'h1;
				end
			end
			nfc_init_pkg::S_WAIT: begin
				if (s_r.fp2) begin
					ev.eon = 1'b1;
					n.state = nfc_init_pkg::S_MASK;
					n.cnt = {16'h0000, s_r.mrt};
				end else if (s_r.cnt == 32'h0) begin
					ev.nre = 1'b1;
					n.state = nfc_init_pkg::S_IDLE;
				end else begin
					n.cnt = s_r.cnt - 32'h1;
				end
			end
			nfc_init_pkg::S_MASK: begin
				if (s_r.cnt == 32'h0) begin
					n.state = nfc_init_pkg::S_RX;
					n.rx_n = '0;
					n.crc = nfc_init_pkg::CRC_PRESET;
				end else begin
					n.cnt = s_r.cnt - 32'h1;
				end
			end
			nfc_init_pkg::S_RX: begin
				if (RX_I.start) begin
					n.rx_n = '0;
					n.crc = nfc_init_pkg::CRC_PRESET;
				end else if (RX_I.valid) begin
					n.crc = nfc_init_pkg::crc_byte(s_r.crc, RX_I.data);
					if (s_r.rx_n != 9'h1FF) begin
						n.rx_n = s_r.rx_n + 9'h001;
					end
					if (s_r.rx_n == 9'h000) begin
						if (RX_I.data != nfc_init_pkg::START_BYTE) begin
							ev.soft_err = 1'b1;
						end
					end else begin
						// two-byte delay keeps the CRC bytes out of the fifo
						n.h0 = RX_I.data;
						n.h1 = s_r.h0;
						if (s_r.rx_n >= 9'h003) begin
							n.fw.valid = 1'b1;
							n.fw.data = s_r.h1;
						end
					end
					if (RX_I.last) begin
						ev.rx_end = 1'b1;
						if (n.crc != nfc_init_pkg::CRC_RESIDUE) begin
							ev.crc_err = 1'b1;
						end
					end
				end
			end
			nfc_init_pkg::S_IDLE: begin
			end
			default: begin
				n.state = nfc_init_pkg::S_IDLE;
			end
		endcase

		// target field dropped while listening
		if ((s_r.state == nfc_init_pkg::S_MASK || s_r.state == nfc_init_pkg::S_RX)
			&& !s_r.fp2) begin
			ev.eof = 1'b1;
			if (s_r.ctrl.auto_response_ca_enable) begin
				n.state = nfc_init_pkg::S_CA;
				n.resp = 1'b1;
				n.thr_ca = 1'b1;
				n.cnt = CA_CYC;
			end else begin
				n.state = nfc_init_pkg::S_IDLE;
			end
		end

		// a new event wins over a clear in the same cycle
		n.evt = (s_r.evt & ~clr) | ev;
		s_nxt = n;
	end

	// =========================================================
	// registers
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			s_r <= '0;
			s_r.awready <= 1'b1;
			s_r.wready <= 1'b1;
			s_r.arready <= 1'b1;
			s_r.ctrl <= nfc_init_pkg::CTRL_RST;
			s_r.txcnt <= nfc_init_pkg::TXCNT_RST;
			s_r.gpt <= nfc_init_pkg::GPT_RST;
			s_r.nrt <= nfc_init_pkg::NRT_RST;
			s_r.mrt <= nfc_init_pkg::MRT_RST;
			s_r.state <= nfc_init_pkg::S_IDLE;
			s_r.crc <= nfc_init_pkg::CRC_PRESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// =========================================================
	// outputs
	assign AXI_RSP_O = '{awready: s_r.awready, wready: s_r.wready,
		bvalid: s_r.bvalid, bresp: s_r.bresp, arready: s_r.arready,
		rvalid: s_r.rvalid, rdata: s_r.rdata, rresp: s_r.rresp};
	assign FD_EN_O = s_r.ctrl.ext_field_detect_enable;
	assign THR_CA_O = s_r.thr_ca;
	assign TX_EN_O = s_r.tx_en;
	assign AM_EN_O = s_r.ctrl.am_en;
	assign PM_EN_O = s_r.ctrl.pm_en;
	assign RATE_O = s_r.ctrl.rate;
	assign TX_O = s_r.tx;
	assign FIFO_RE_O = s_r.fifo_re;
	assign FIFO_W_O = s_r.fw;

	// =========================================================
	// checks
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (SRST_I);

	sequence s_target_on;
		s_r.state == nfc_init_pkg::S_WAIT && s_r.fp2;
	endsequence
	sequence s_masking;
		s_r.state == nfc_init_pkg::S_MASK && s_r.evt.eon;
	endsequence

	chk_start_byte: assert property (s_r.state == nfc_init_pkg::S_TX
		&& TX_O.valid && s_r.pos == 9'h001
		|-> TX_O.data == nfc_init_pkg::START_BYTE)
		else $error("start byte not sent first");
	chk_length_byte: assert property (s_r.state == nfc_init_pkg::S_TX
		&& TX_O.valid && s_r.pos == 9'h002
		|-> TX_O.data == s_r.txcnt + 8'h01)
		else $error("length byte is not count plus one");
	chk_no_resend: assert property (s_r.state == nfc_init_pkg::S_TX
		&& TX_O.valid && TX_READY_I && s_r.fifo_re |=> !TX_O.valid)
		else $error("byte taken during fifo refresh sent again");
	chk_soft_frame: assert property (s_r.state == nfc_init_pkg::S_RX
		&& !RX_I.start && RX_I.valid && s_r.rx_n == 9'h000
		&& RX_I.data != nfc_init_pkg::START_BYTE |=> s_r.evt.soft_err)
		else $error("bad start byte not flagged");
	chk_field_off: assert property (s_r.state == nfc_init_pkg::S_HOLD
		&& s_r.cnt == 32'h0 |=> !TX_EN_O && s_r.state == nfc_init_pkg::S_WAIT)
		else $error("field not switched off after hold");
	chk_no_response: assert property (s_r.state == nfc_init_pkg::S_WAIT
		&& !s_r.fp2 && s_r.cnt == 32'h0
		|=> s_r.evt.nre && s_r.state == nfc_init_pkg::S_IDLE)
		else $error("no-response timeout not flagged");
	chk_target_on: assert property (s_target_on |=> s_masking
		##1 (s_r.state == nfc_init_pkg::S_MASK || !s_r.fp2 || s_r.cnt == 32'h0
		|| s_r.state == nfc_init_pkg::S_RX))
		else $error("target field not followed by mask");
	chk_ca_collision: assert property (s_r.state == nfc_init_pkg::S_CA
		&& s_r.fc2 |=> s_r.evt.cac && !TX_EN_O
		&& s_r.state == nfc_init_pkg::S_IDLE)
		else $error("collision did not keep field off");
	chk_guard_done: assert property (s_r.state == nfc_init_pkg::S_GUARD
		&& s_r.cnt == 32'h0 |=> s_r.evt.cat && TX_EN_O)
		else $error("guard end without done flag");
	chk_auto_resp: assert property (s_r.state == nfc_init_pkg::S_RX
		&& !s_r.fp2 && s_r.ctrl.auto_response_ca_enable
		|=> s_r.state == nfc_init_pkg::S_CA && s_r.resp && THR_CA_O
		&& s_r.evt.eof)
		else $error("field drop did not start response avoidance");
endmodule : nfc_active_initiator_seq

// file: test/nfc_target_model.sv
`timescale 1ns/1ps
// =========================================================
// far-side target: takes the transmit stream, drives field and reply
module nfc_target_model (
	// clock
	input wire logic clk_i,
	// transmit stream from the initiator
	input wire nfc_init_pkg::byte_out_t tx_i,
	output logic tx_ready_o,
	// field detector pins
	output logic field_peer_o,
	output logic field_ca_o,
	// demodulated reply
	output nfc_init_pkg::rx_in_t rx_o
);
	logic [7:0] got[$];
	logic slow;
	logic ph;

	initial begin
		slow = 1'b0;
		ph = 1'b0;
		tx_ready_o = 1'b0;
		field_peer_o = 1'b0;
		field_ca_o = 1'b0;
		rx_o = '0;
	end

	// slow mode takes a byte only every other cycle
	always @(posedge clk_i) begin
		ph <= ~ph;
		tx_ready_o <= ~slow | ph;
		if (tx_i.valid && tx_ready_o)
			got.push_back(tx_i.data);
	end

	// target field on while it answers, off while it listens
	task automatic field(input logic peer, input logic ca);
		@(posedge clk_i);
		field_peer_o <= peer;
		field_ca_o <= ca;
	endtask : field

	// idle data lines show the inverse of the last byte
	task automatic send(input logic [7:0] b[$]);
		@(posedge clk_i);
		rx_o <= '{1'b1, 1'b0, 1'b0, ~rx_o.data};
		foreach (b[i]) begin
			@(posedge clk_i);
			rx_o <= '{1'b0, 1'b1, i == b.size() - 1, b[i]};
			@(posedge clk_i);
			rx_o <= '{1'b0, 1'b0, 1'b0, ~b[i]};
		end
	endtask : send
endmodule : nfc_target_model

// file: test/nfc_active_initiator_seq_bench.sv
`timescale 1ns/1ps
module nfc_active_initiator_seq_bench;
	localparam int LIM = 400;
	logic clk;
	logic srst;
	nfc_init_pkg::axil_req_t req;
	nfc_init_pkg::axil_rsp_t rsp;
	nfc_init_pkg::byte_out_t tx;
	nfc_init_pkg::byte_out_t fw;
	nfc_init_pkg::rx_in_t rx;
	logic tx_ready, peer, ca, fd_en, thr_ca, tx_en, am_en, pm_en, fifo_re;
	logic [1:0] rate;
	logic [7:0] txf [0:7];
	logic [7:0] rxq[$];
	int fp = 0;
	int err_count;
	int checks_done;
	logic [31:0] d;
	logic [1:0] r;

	nfc_active_initiator_seq #(
		.CA_CYC(4),
		.INIT_GUARD_CYC(4),
		.RESP_GUARD_CYC(4)
	) dut (
		.CLK_I(clk), .SRST_I(srst), .AXI_REQ_I(req), .AXI_RSP_O(rsp),
		.FIELD_PEER_I(peer), .FIELD_CA_I(ca), .FD_EN_O(fd_en),
		.THR_CA_O(thr_ca), .TX_EN_O(tx_en), .AM_EN_O(am_en),
		.PM_EN_O(pm_en), .RATE_O(rate), .TX_O(tx), .TX_READY_I(tx_ready),
		.RX_I(rx), .FIFO_RDATA_I(txf[fp[2:0]]), .FIFO_RE_O(fifo_re),
		.FIFO_W_O(fw)
	);

	nfc_target_model tgt (
		.clk_i(clk), .tx_i(tx), .tx_ready_o(tx_ready),
		.field_peer_o(peer), .field_ca_o(ca), .rx_o(rx)
	);

	// =========================================================
	// clock, fifo model, shared tasks
	always #50 clk = ~clk;
	always @(posedge clk) begin
		if (fifo_re)
			fp <= fp + 1;
		if (fw.valid)
			rxq.push_back(fw.data);
	end

	function automatic logic [15:0] crc(input logic [7:0] q[$]);
		logic [15:0] c;
		c = nfc_init_pkg::CRC_PRESET;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? (c >> 1) ^ nfc_init_pkg::CRC_POLY : c >> 1;
		end
		return c;
	endfunction : crc

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic tmo(input string nm);
		err_count++;
		$display("CHECK FAILED %s expected done seen timeout", nm);
		end_of_test();
	endtask : tmo

	task automatic qchk(input string nm, input logic [7:0] e[$],
		input logic [7:0] s[$]);
		chk(nm, e.size(), s.size());
		foreach (e[i])
			if (i < s.size())
				chk(nm, e[i], s[i]);
	endtask : qchk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		req.awvalid <= 1'b1;
		req.awaddr <= {24'h0, a};
		req.wvalid <= 1'b1;
		req.wdata <= v;
		req.wstrb <= 4'hF;
		do begin
			@(posedge clk);
			n++;
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1 && n < 50);
		r = rsp.bresp;
		if (n >= 50)
			tmo("write response");
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		req.arvalid <= 1'b1;
		req.araddr <= {24'h0, a};
		do begin
			@(posedge clk);
			n++;
			if (rsp.arready)
				req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1 && n < 50);
		d = rsp.rdata;
		r = rsp.rresp;
		if (n >= 50)
			tmo("read response");
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		rd(a);
		chk(nm, e, d);
	endtask : rc

	// poll status until the masked bits equal v
	task automatic wst(input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		d = ~v;
		while ((d & m) !== v && n < 300) begin
			rd(nfc_init_pkg::A_STAT);
			n++;
		end
		if ((d & m) !== v)
			tmo("status wait");
	endtask : wst

	task automatic tx_frame(input int n);
		logic [7:0] e[$];
		logic [15:0] c;
		int k;
		tgt.got = {};
		e = {nfc_init_pkg::START_BYTE, 8'(n + 1)};
		for (int i = 0; i < n; i++)
			e.push_back(txf[3'(fp + i)]);
		c = crc(e);
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
		wr(nfc_init_pkg::A_TXCNT, 32'(n));
		wr(nfc_init_pkg::A_CMD, 32'h3);
		k = 0;
		while (tgt.got.size() < e.size() && k < LIM) begin
			@(posedge clk);
			k++;
		end
		k = 0;
		while (tx_en === 1'b1 && k < LIM) begin
			@(posedge clk);
			k++;
		end
		if (k >= LIM)
			tmo("transmit");
		qchk("tx bytes", e, tgt.got);
		chk("hold cycles", 1, k >= 16 && k <= 20);
	endtask : tx_frame

	task automatic rx_frame(input logic [7:0] sb, input logic [7:0] dat[$],
		input logic bad);
		logic [7:0] f[$];
		logic [7:0] e[$];
		logic [15:0] c;
		e = dat;
		e.push_front(8'(dat.size() + 1));
		f = {sb, e};
		c = bad ? 16'h0000 : crc(f);
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		rxq = {};
		tgt.field(1'b1, 1'b1);
		wst(32'h4, 32'h4);
		wst(32'hF00, 32'h700);
		chk("field while receiving", 0, tx_en);
		tgt.send(f);
		wst(32'h20, 32'h20);
		qchk("rx fifo", e, rxq);
		chk("start error", sb !== nfc_init_pkg::START_BYTE, d[7]);
		chk("crc error", bad, d[6]);
	endtask : rx_frame

	// =========================================================
	// main sequence
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		req = '0;
		req.bready = 1'b1;
		req.rready = 1'b1;
		err_count = 0;
		checks_done = 0;
		txf = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'hE5, 8'hF6, 8'h17, 8'h28};
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rc(nfc_init_pkg::A_CTRL, nfc_init_pkg::CTRL_RST, "ctrl reset");
		rc(nfc_init_pkg::A_GPT, 32'(nfc_init_pkg::GPT_RST), "gpt reset");
		rc(nfc_init_pkg::A_NRT, 32'(nfc_init_pkg::NRT_RST), "nrt reset");
		rc(nfc_init_pkg::A_MRT, 32'(nfc_init_pkg::MRT_RST), "mrt reset");
		rd(8'h40);
		chk("unmapped read", nfc_init_pkg::RESP_SLVERR, r);
		wr(8'h44, 32'h1);
		chk("unmapped write", nfc_init_pkg::RESP_SLVERR, r);
		wr(nfc_init_pkg::A_CTRL, 32'h1);
		rc(nfc_init_pkg::A_CTRL, 32'h9, "ctrl active");
		chk("detector enable", 1, fd_en);
		wr(nfc_init_pkg::A_CMD, 32'h4);
		rc(nfc_init_pkg::A_CTRL, 32'h219, "ctrl preset");
		chk("am channel", 1, am_en);
		chk("pm channel", 0, pm_en);
		for (int i = 2; i >= 0; i--) begin
			wr(nfc_init_pkg::A_CTRL, 32'h219 | (i << 5));
			chk("bit rate", i, rate);
		end
		wr(nfc_init_pkg::A_CTRL, 32'h21D);
		tgt.field(1'b0, 1'b1);
		repeat (3) @(posedge clk);
		wr(nfc_init_pkg::A_CMD, 32'h1);
		chk("ca threshold", 1, thr_ca);
		wst(32'h2, 32'h2);
		chk("field after collision", 0, tx_en);
		wr(nfc_init_pkg::A_STAT, 32'hFF);
		tgt.field(1'b0, 1'b0);
		repeat (3) @(posedge clk);
		wr(nfc_init_pkg::A_CMD, 32'h1);
		wst(32'h1, 32'h1);
		chk("field on", 1, tx_en);
		chk("peer threshold", 0, thr_ca);
		tx_frame(2);
		rx_frame(nfc_init_pkg::START_BYTE, {8'hC1, 8'hC2}, 1'b0);
		wr(nfc_init_pkg::A_STAT, 32'hFF);
		tgt.field(1'b0, 1'b0);
		wst(32'h9, 32'h9);
		chk("response field", 1, tx_en);
		wr(nfc_init_pkg::A_CTRL, 32'h219);
		wr(nfc_init_pkg::A_STAT, 32'hFF);
		tgt.slow <= 1'b1;
		tx_frame(0);
		rx_frame(8'h0F, {8'hD1}, 1'b1);
		tgt.field(1'b0, 1'b0);
		wst(32'hF08, 32'h008);
		repeat (20) @(posedge clk);
		chk("no response field", 0, tx_en);
		wr(nfc_init_pkg::A_STAT, 32'hFF);
		wr(nfc_init_pkg::A_NRT, 32'h20);
		wr(nfc_init_pkg::A_CMD, 32'h1);
		wst(32'h1, 32'h1);
		tx_frame(3);
		wst(32'hF10, 32'h010);
		chk("field after silence", 0, tx_en);
		wr(nfc_init_pkg::A_STAT, 32'hFF);
		wr(nfc_init_pkg::A_CMD, 32'h2);
		wst(32'hF01, 32'h001);
		chk("response field on", 1, tx_en);
		end_of_test();
	end
endmodule : nfc_active_initiator_seq_bench
